//--- dual_timer_pkg.sv
// Package of constants and types for the cascadable dual 8-bit timer.
//
// Notes on behaviour
// - Upper mode 1xx clocks the upper byte from lower overflow, ignoring clock select.
// - 16-bit: clock from lower select; run from upper bits.
// - Counters run alone as 8-bit units or cascade into one 16-bit counter.
// - Timer mode counts selected clock; match raises interrupt and clears counter.
// - After a match clear, counting resumes from zero by itself.
// - Period compare has no shadow; a write takes effect at once.
// - Slowest tap is fc/2^11 or fs/2^3 by stage select; fs/2^3 when slow.
// - Clock select codes: 000 slowest, 001..110 taps, 111 count pin.
// - Mode codes 000 to 111 as timer, divider, PWM, cascade low, 16-bit modes.
// - Clearing the start bit stops and clears the counter; setting starts it.
package dual_timer_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0] ADDR_LOWER_CTRL = 4'h0;
  localparam logic [3:0] ADDR_UPPER_CTRL = 4'h1;
  localparam logic [3:0] ADDR_LOWER_PERIOD = 4'h2;
  localparam logic [3:0] ADDR_UPPER_PERIOD = 4'h3;
  localparam logic [3:0] ADDR_LOWER_DUTY = 4'h4;
  localparam logic [3:0] ADDR_UPPER_DUTY = 4'h5;
  localparam logic [3:0] ADDR_LOWER_COUNT = 4'h6;
  localparam logic [3:0] ADDR_UPPER_COUNT = 4'h7;
  localparam logic [3:0] ADDR_MISC = 4'h8;
  localparam int ADDR_W = 4;

  // Control register fields.
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_RUN_BIT = 3;
  localparam int CTRL_CLK_LSB = 4;
  localparam int CTRL_FF_BIT = 7;
  localparam int MISC_STAGE_BIT = 0;
  localparam int MISC_SLOW_BIT = 1;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] PERIOD_RESET = 8'hFF;
  localparam logic [7:0] DUTY_RESET = 8'hFF;

  // ****************************************
  // Encodings
  // ****************************************
  localparam logic [2:0] MODE_TIMER8 = 3'h0;
  localparam logic [2:0] MODE_DIVIDER8 = 3'h1;
  localparam logic [2:0] MODE_PWM8 = 3'h2;
  localparam logic [2:0] MODE_CASCADE_LOW = 3'h3;
  localparam logic [2:0] CLK_SLOWEST = 3'h0;
  localparam logic [2:0] CLK_PIN = 3'h7;
  localparam int MODE_WIDE_BIT = 2;

  // Prescaler tap positions for fc/2^n.
  localparam int TAP_FC_11 = 10;
  localparam int TAP_FC_7 = 6;
  localparam int TAP_FC_5 = 4;
  localparam int TAP_FC_3 = 2;
  localparam int TAP_FC_1 = 0;
  localparam int TAP_FS_3 = 2;
  localparam int FC_DIV_W = 11;
  localparam int FS_DIV_W = 3;

  // Decoded fields of one control register.
  typedef struct packed {
    logic ff_ctrl;
    logic [2:0] clk_sel;
    logic run;
    logic [2:0] mode;
  } ctrl_t;

endpackage : dual_timer_pkg

//--- timer_unit.sv
// One 8-bit up-counter with period compare and timer-mode match handling.
`timescale 1ns/1ps
module timer_unit
  import dual_timer_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic tick,
  input wire logic [WIDTH-1:0] period,
  input wire logic match_enable,
  output logic [WIDTH-1:0] count,
  output logic match,
  output logic wrap
);

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  logic hit;

  // Period compared live, with no shadow stage.
  assign hit = match_enable && tick && (count_reg == period);

  // A match clears to zero and counting goes on alone; stop clears too.
  always_comb begin
    count_next = count_reg;
    if (!run) begin
      count_next = '0;
    end else if (hit) begin
      count_next = '0;
    end else if (tick) begin
      count_next = count_reg + 1'b1;
    end
  end

  // Counter register.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign count = count_reg;
  assign match = run && hit;
  // Overflow feeds the cascade clock of the upper byte.
  assign wrap = run && tick && !hit && (count_reg == {WIDTH{1'b1}});

endmodule : timer_unit

//--- dual_timer.sv
// Top of the cascadable dual 8-bit timer with its register port.
`timescale 1ns/1ps
module dual_timer
  import dual_timer_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic fs_tick,
  input wire logic lower_count_pin,
  input wire logic upper_count_pin,
  output logic lower_compare_match_irq,
  output logic upper_compare_match_irq
);

  // ****************************************
  // Registers
  // ****************************************
  ctrl_t lower_control_reg;
  ctrl_t upper_control_reg;
  logic [7:0] lower_period_reg;
  logic [7:0] upper_period_reg;
  logic [7:0] lower_duty_reg;
  logic [7:0] upper_duty_reg;
  logic divider_stage_select_reg;
  logic slow_state_reg;
  logic [7:0] reg_rdata_reg;
  logic lower_irq_reg;
  logic upper_irq_reg;
  logic [FC_DIV_W-1:0] fc_div_reg;
  logic [FS_DIV_W-1:0] fs_div_reg;
  logic lower_pin_reg;
  logic upper_pin_reg;

  logic wide_mode;
  logic lower_tick;
  logic upper_tick;
  logic lower_run;
  logic upper_run;
  logic [7:0] lower_count;
  logic [7:0] upper_count;
  logic lower_match;
  logic upper_match;
  logic lower_wrap;
  logic upper_wrap;
  logic [FC_DIV_W-1:0] fc_rise;
  logic fs3_rise;

  // Register writes from software.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lower_control_reg <= CTRL_RESET;
      upper_control_reg <= CTRL_RESET;
      lower_period_reg <= PERIOD_RESET;
      upper_period_reg <= PERIOD_RESET;
      lower_duty_reg <= DUTY_RESET;
      upper_duty_reg <= DUTY_RESET;
      divider_stage_select_reg <= 1'b0;
      slow_state_reg <= 1'b0;
    end else if (reg_write) begin
      case (reg_addr)
        ADDR_LOWER_CTRL: lower_control_reg <= reg_wdata;
        ADDR_UPPER_CTRL: upper_control_reg <= reg_wdata;
        ADDR_LOWER_PERIOD: lower_period_reg <= reg_wdata;
        ADDR_UPPER_PERIOD: upper_period_reg <= reg_wdata;
        ADDR_LOWER_DUTY: lower_duty_reg <= reg_wdata;
        ADDR_UPPER_DUTY: upper_duty_reg <= reg_wdata;
        ADDR_MISC: begin
          divider_stage_select_reg <= reg_wdata[MISC_STAGE_BIT];
          slow_state_reg <= reg_wdata[MISC_SLOW_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // Read data stand in the cycle after the read strobe; unmapped reads zero.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata_reg <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        ADDR_LOWER_CTRL: reg_rdata_reg <= lower_control_reg;
        ADDR_UPPER_CTRL: reg_rdata_reg <= upper_control_reg;
        ADDR_LOWER_PERIOD: reg_rdata_reg <= lower_period_reg;
        ADDR_UPPER_PERIOD: reg_rdata_reg <= upper_period_reg;
        ADDR_LOWER_DUTY: reg_rdata_reg <= lower_duty_reg;
        ADDR_UPPER_DUTY: reg_rdata_reg <= upper_duty_reg;
        ADDR_LOWER_COUNT: reg_rdata_reg <= lower_count;
        ADDR_UPPER_COUNT: reg_rdata_reg <= upper_count;
        ADDR_MISC: reg_rdata_reg <= {6'h00, slow_state_reg, divider_stage_select_reg};
        default: reg_rdata_reg <= 8'h00;
      endcase
    end else begin
      reg_rdata_reg <= 8'h00;
    end
  end

  // ****************************************
  // Prescaler
  // ****************************************
  // Free-running fc and fs dividers; a tap ticks when its bit rises.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      fc_div_reg <= '0;
    end else begin
      fc_div_reg <= fc_div_reg + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      fs_div_reg <= '0;
    end else if (fs_tick) begin
      fs_div_reg <= fs_div_reg + 1'b1;
    end
  end

  // Count pins: falling edge counts one event.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lower_pin_reg <= 1'b0;
      upper_pin_reg <= 1'b0;
    end else begin
      lower_pin_reg <= lower_count_pin;
      upper_pin_reg <= upper_count_pin;
    end
  end

  // A tap of fc/2^(n+1) rises when the low n+1 bits of the divider are all ones.
  always_comb begin
    fc_rise = '0;
    for (int i = 0; i < FC_DIV_W; i++) begin
      fc_rise[i] = (fc_div_reg & ((FC_DIV_W'(1) << (i + 1)) - FC_DIV_W'(1)))
                   == ((FC_DIV_W'(1) << (i + 1)) - FC_DIV_W'(1));
    end
  end

  assign fs3_rise = fs_tick && (fs_div_reg == {FS_DIV_W{1'b1}});

  // Clock select decode; the slowest tap depends on stage select and state.
  function automatic logic pick_tick(input logic [2:0] sel, input logic pin_fall);
    logic t;
    t = 1'b0;
    case (sel)
      CLK_SLOWEST: begin
        if (slow_state_reg || divider_stage_select_reg) begin
          t = fs3_rise;
        end else begin
          t = fc_rise[TAP_FC_11];
        end
      end
      3'h1: t = fc_rise[TAP_FC_7];
      3'h2: t = fc_rise[TAP_FC_5];
      3'h3: t = fc_rise[TAP_FC_3];
      3'h4: t = fs_tick;
      3'h5: t = fc_rise[TAP_FC_1];
      3'h6: t = 1'b1;
      CLK_PIN: t = pin_fall;
      default: t = 1'b0;
    endcase
    return t;
  endfunction : pick_tick

  // ****************************************
  // Counters and cascade
  // ****************************************
  assign wide_mode = upper_control_reg.mode[MODE_WIDE_BIT];
  // In 16-bit modes the upper start bit runs both halves.
  assign lower_run = wide_mode ? upper_control_reg.run : lower_control_reg.run;
  assign upper_run = upper_control_reg.run;
  // Tick selection sits in a process so that the taps and state bits read inside the function wake it.
  always_comb begin
    // Lower clock select drives the pair in 16-bit modes.
    lower_tick = pick_tick(lower_control_reg.clk_sel, lower_pin_reg && !lower_count_pin);
    // In 16-bit modes the upper byte takes the lower overflow whatever the clock selects say.
    upper_tick = wide_mode ? lower_wrap
               : pick_tick(upper_control_reg.clk_sel, upper_pin_reg && !upper_count_pin);
  end

  timer_unit #(
    .WIDTH(8)
  ) u_lower (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .run(lower_run),
    .tick(lower_tick),
    .period(lower_period_reg),
    .match_enable(!wide_mode && lower_control_reg.mode == MODE_TIMER8),
    .count(lower_count),
    .match(lower_match),
    .wrap(lower_wrap)
  );

  timer_unit #(
    .WIDTH(8)
  ) u_upper (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .run(upper_run),
    .tick(upper_tick),
    .period(upper_period_reg),
    .match_enable(upper_control_reg.mode == MODE_TIMER8),
    .count(upper_count),
    .match(upper_match),
    .wrap(upper_wrap)
  );

  // Compare interrupts follow each match one cycle later; a match in consecutive cycles keeps them high.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lower_irq_reg <= 1'b0;
      upper_irq_reg <= 1'b0;
    end else begin
      lower_irq_reg <= lower_match;
      upper_irq_reg <= upper_match;
    end
  end

  assign reg_rdata = reg_rdata_reg;
  assign lower_compare_match_irq = lower_irq_reg;
  assign upper_compare_match_irq = upper_irq_reg;

  // ****************************************
  // Checks
  // ****************************************
  property p_irq_follows_match;
    @(posedge core_clk) disable iff (sys_rst)
      lower_match |=> lower_compare_match_irq && lower_count == 8'h00;
  endproperty
  a_irq_follows_match: assert property (p_irq_follows_match) else $error("lower irq missing after match");

  property p_irq_single;
    @(posedge core_clk) disable iff (sys_rst)
      upper_compare_match_irq |=> !upper_compare_match_irq;
  endproperty
  a_irq_single: assert property (p_irq_single) else $error("upper irq longer than one cycle");

  property p_stop_clears;
    @(posedge core_clk) disable iff (sys_rst)
      !upper_run |=> upper_count == 8'h00;
  endproperty
  a_stop_clears: assert property (p_stop_clears) else $error("stopped upper counter not clear");

  property p_cascade_clock;
    @(posedge core_clk) disable iff (sys_rst)
      (wide_mode && upper_run && !lower_wrap) |=> upper_count == $past(upper_count);
  endproperty
  a_cascade_clock: assert property (p_cascade_clock) else $error("upper byte moved without overflow");

  property p_resume;
    @(posedge core_clk) disable iff (sys_rst)
      (lower_match ##1 lower_run && lower_tick) |=> lower_count == 8'h01;
  endproperty
  a_resume: assert property (p_resume) else $error("lower counter did not resume from zero");

  property p_live_period;
    @(posedge core_clk) disable iff (sys_rst)
      (upper_run && upper_tick && upper_control_reg.mode == MODE_TIMER8
       && upper_count == upper_period_reg) |-> upper_match;
  endproperty
  a_live_period: assert property (p_live_period) else $error("match on live period missed");

  property p_wide_run;
    @(posedge core_clk) disable iff (sys_rst)
      (wide_mode && !upper_control_reg.run) |=> lower_count == 8'h00;
  endproperty
  a_wide_run: assert property (p_wide_run) else $error("lower half ran without upper start bit");

  property p_slow_tap;
    @(posedge core_clk) disable iff (sys_rst)
      (slow_state_reg && lower_control_reg.clk_sel == CLK_SLOWEST && !fs_tick) |-> !lower_tick;
  endproperty
  a_slow_tap: assert property (p_slow_tap) else $error("slowest tap not from fs in slow state");

  property p_upper_irq_follows;
    @(posedge core_clk) disable iff (sys_rst)
      upper_match |=> upper_compare_match_irq && upper_count == 8'h00;
  endproperty
  a_upper_irq_follows: assert property (p_upper_irq_follows) else $error("upper irq missing after match");

  property p_lower_irq_single;
    @(posedge core_clk) disable iff (sys_rst)
      lower_compare_match_irq |=> !lower_compare_match_irq;
  endproperty
  a_lower_irq_single: assert property (p_lower_irq_single) else $error("lower irq longer than one cycle");

  property p_lower_stop_clears;
    @(posedge core_clk) disable iff (sys_rst)
      !lower_run |=> lower_count == 8'h00;
  endproperty
  a_lower_stop_clears: assert property (p_lower_stop_clears) else $error("stopped lower counter not clear");

  property p_fast_slowest_tap;
    @(posedge core_clk) disable iff (sys_rst)
      (!slow_state_reg && !divider_stage_select_reg && lower_control_reg.clk_sel == CLK_SLOWEST && lower_tick)
      |-> &fc_div_reg;
  endproperty
  a_fast_slowest_tap: assert property (p_fast_slowest_tap) else $error("slowest tap not from fc divider");

  property p_upper_resume;
    @(posedge core_clk) disable iff (sys_rst)
      (upper_match ##1 upper_run && upper_tick) |=> upper_count == 8'h01;
  endproperty
  a_upper_resume: assert property (p_upper_resume) else $error("upper counter did not resume from zero");

  property p_no_wide_match;
    @(posedge core_clk) disable iff (sys_rst)
      wide_mode |-> !lower_match && !upper_match;
  endproperty
  a_no_wide_match: assert property (p_no_wide_match) else $error("timer match while cascaded");

endmodule : dual_timer

//--- tb_top.sv
// Self-checking testbench for the cascadable dual 8-bit timer.
`timescale 1ns/1ps
`define CHK(act, exp) begin cmp_count++; if ((act) !== (exp)) begin err_count++; \
  $display("Error at %0t: got %0h expected %0h", $time, act, exp); end end
module tb_top
  import dual_timer_pkg::*;
;
  logic core_clk;
  logic sys_rst;
  logic [ADDR_W-1:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_write;
  logic reg_read;
  logic [7:0] reg_rdata;
  logic fs_tick;
  logic lower_count_pin;
  logic upper_count_pin;
  logic lower_compare_match_irq;
  logic upper_compare_match_irq;
  logic [3:0] fs_div;
  int err_count;
  int cmp_count;
  int cycle_count;

  dual_timer u_dut (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_rdata(reg_rdata),
    .fs_tick(fs_tick),
    .lower_count_pin(lower_count_pin),
    .upper_count_pin(upper_count_pin),
    .lower_compare_match_irq(lower_compare_match_irq),
    .upper_compare_match_irq(upper_compare_match_irq)
  );

  // ****************************************
  // Clock, low-frequency tick and watchdog
  // ****************************************
  // The clock runs at 100 MHz.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // One low-frequency tick every ten core cycles keeps fs-based taps short.
  always @(posedge core_clk) begin
    fs_div <= (fs_div == 4'h9) ? 4'h0 : fs_div + 4'h1;
    fs_tick <= (fs_div == 4'h9);
  end

  // A hang is cut short well beyond the expected run length.
  always @(posedge core_clk) begin
    cycle_count++;
    if (cycle_count == 60000) begin
      err_count++;
      results();
    end
  end

  // ****************************************
  // Register bus and helpers
  // ****************************************
  // One-cycle write strobe beside address and data.
  task automatic wr(input logic [3:0] addr, input logic [7:0] data);
    @(posedge core_clk);
    reg_write <= 1'b1;
    reg_addr <= addr;
    reg_wdata <= data;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask : wr

  // One-cycle read strobe; the data stand only in the following cycle.
  task automatic rd(input logic [3:0] addr, output logic [7:0] data);
    @(posedge core_clk);
    reg_read <= 1'b1;
    reg_addr <= addr;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1;
    data = reg_rdata;
  endtask : rd

  // Counts settled cycles until the chosen unit's interrupt shows high.
  task automatic wait_irq(input logic up, output int n);
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (((up ? upper_compare_match_irq : lower_compare_match_irq) !== 1'b1) && n < 10000);
    if (n >= 10000) begin
      err_count++;
      $display("Error at %0t: got %0h expected %0h", $time, n, 0);
    end
  endtask : wait_irq

  // ****************************************
  // Scenarios
  // ****************************************
  // Starts a unit in timer mode, measures the first latency and the match period, then stops it.
  task automatic irq_gap(input logic up, input logic [7:0] per, input logic [7:0] ctrl,
                         input logic [7:0] misc, input int first, input int gap);
    int n;
    wr(ADDR_MISC, misc);
    wr(up ? ADDR_UPPER_PERIOD : ADDR_LOWER_PERIOD, per);
    wr(up ? ADDR_UPPER_CTRL : ADDR_LOWER_CTRL, ctrl);
    wait_irq(up, n);
    if (first > 0) `CHK(n, first)
    wait_irq(up, n);
    `CHK(n, gap)
    @(posedge core_clk);
    #1;
    `CHK(up ? upper_compare_match_irq : lower_compare_match_irq, 1'b0)
    wr(up ? ADDR_UPPER_CTRL : ADDR_LOWER_CTRL, ctrl & 8'hF7);
  endtask : irq_gap

  // Reset values, read-only counts and an unmapped address.
  task automatic reset_values();
    logic [7:0] d;
    rd(ADDR_LOWER_CTRL, d);
    `CHK(d, CTRL_RESET)
    rd(ADDR_UPPER_PERIOD, d);
    `CHK(d, PERIOD_RESET)
    rd(ADDR_LOWER_DUTY, d);
    `CHK(d, DUTY_RESET)
    wr(4'hF, 8'h5A);
    rd(4'hF, d);
    `CHK(d, 8'h00)
    wr(ADDR_LOWER_COUNT, 8'h33);
    rd(ADDR_LOWER_COUNT, d);
    `CHK(d, 8'h00)
  endtask : reset_values

  // Stopping clears the count and holds it at zero.
  task automatic run_clear();
    logic [7:0] d;
    wr(ADDR_MISC, 8'h00);
    wr(ADDR_LOWER_PERIOD, 8'hFF);
    wr(ADDR_LOWER_CTRL, 8'h38);
    repeat (20) @(posedge core_clk);
    rd(ADDR_LOWER_COUNT, d);
    `CHK(d != 8'h00, 1'b1)
    wr(ADDR_LOWER_CTRL, 8'h30);
    repeat (5) @(posedge core_clk);
    rd(ADDR_LOWER_COUNT, d);
    `CHK(d, 8'h00)
  endtask : run_clear

  // Cascade: the upper byte steps on lower overflow and ignores its own fc/2^3 clock select.
  task automatic cascade();
    logic [7:0] d;
    wr(ADDR_LOWER_CTRL, {1'b0, 3'h3, 1'b0, MODE_CASCADE_LOW});
    wr(ADDR_UPPER_CTRL, {1'b0, 3'h3, 1'b1, 3'h4});
    repeat (2100) @(posedge core_clk);
    rd(ADDR_UPPER_COUNT, d);
    `CHK(d, 8'h01)
    wr(ADDR_UPPER_CTRL, {1'b0, 3'h3, 1'b0, 3'h4});
    rd(ADDR_UPPER_COUNT, d);
    `CHK(d, 8'h00)
    wr(ADDR_LOWER_CTRL, 8'h00);
    wr(ADDR_UPPER_CTRL, 8'h00);
  endtask : cascade

  // Other 16-bit modes with legal compare values: the lower half runs from the upper start bit, no interrupt.
  task automatic wide_modes();
    logic [7:0] d;
    logic seen;
    for (int m = 5; m < 8; m++) begin
      wr(ADDR_UPPER_PERIOD, (m == 5) ? 8'h01 : 8'h00);
      wr(ADDR_LOWER_PERIOD, (m == 5) ? 8'h00 : 8'h03);
      wr(ADDR_UPPER_DUTY, 8'h00);
      wr(ADDR_LOWER_DUTY, (m == 6) ? 8'h02 : 8'h01);
      wr(ADDR_LOWER_CTRL, {1'b0, ((m == 5) ? 3'h4 : 3'h3), 1'b0, MODE_CASCADE_LOW});
      wr(ADDR_UPPER_CTRL, {1'b0, 3'h0, 1'b1, 3'(m)});
      seen = 1'b0;
      repeat (100) begin
        @(posedge core_clk);
        #1;
        seen = seen | lower_compare_match_irq | upper_compare_match_irq;
      end
      rd(ADDR_LOWER_COUNT, d);
      `CHK(d != 8'h00, 1'b1)
      `CHK(seen, 1'b0)
      wr(ADDR_UPPER_CTRL, {1'b0, 3'h0, 1'b0, 3'(m)});
    end
    wr(ADDR_LOWER_CTRL, 8'h00);
    wr(ADDR_UPPER_CTRL, 8'h00);
  endtask : wide_modes

  // Closing report and verdict.
  task automatic results();
    $display("Comparisons: %0d, mismatches: %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  // ****************************************
  // Main sequence
  // ****************************************
  // Tap divides for clock select codes 000 to 110 with the stage select at 0.
  int tap_div [7] = '{2048, 128, 32, 8, 10, 2, 1};

  initial begin
    sys_rst = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    fs_tick = 1'b0;
    fs_div = 4'h0;
    lower_count_pin = 1'b1;
    upper_count_pin = 1'b1;
    err_count = 0;
    cmp_count = 0;
    cycle_count = 0;
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    reset_values();
    irq_gap(1'b0, 8'h02, 8'h68, 8'h00, 3, 3);
    irq_gap(1'b0, 8'hFF, 8'h68, 8'h00, 0, 256);
    irq_gap(1'b1, 8'h03, 8'h58, 8'h00, 0, 8);
    for (int i = 0; i < 7; i++) begin
      irq_gap(1'b0, 8'h01, {1'b0, 3'(i), 1'b1, MODE_TIMER8}, 8'h00, 0, 2 * tap_div[i]);
    end
    irq_gap(1'b0, 8'h01, 8'h08, 8'h01, 0, 160);
    irq_gap(1'b0, 8'h01, 8'h08, 8'h02, 0, 160);
    irq_gap(1'b1, 8'h01, 8'h08, 8'h03, 0, 160);
    run_clear();
    cascade();
    wide_modes();
    results();
  end
endmodule : tb_top
